// ==== rtl/adc_seq_regs.svh ====
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH
// Overview of operation
// [R1] channel seven route from two select bits
// [R2] halve input bit; usb id always halved
// [R3] one core, two requests, separate results
// [R4] write bit 23 targets secondary request
// [R5] bit 23 reads zero; secondary unreadable
// [R6] per-request maskable done interrupt
// [R7] earliest triggered request converts first
// [R8] blocked pin trigger dropped during conversion
// [R9] unblocked pin trigger queued, runs next
// [R10] block bit ignores software starts
// [R11] single shot accepts only next pin trigger
// [R12] host clears single shot before rearming
// [R13] two pin triggers queue, primary wins ties; code gives the tie to an unblocked secondary when the primary is blocked
// [R14] ignore bit disregards trigger pin
// [R15] converter disabled ignores all starts
// [R16] host disables converter while reading results
// [R17] host sets route select for panel
// [R18] three-bit panel mode field decode
// [R19] pen mode bias, dual-edge 30 ms debounce
// [R20] inactive mode terminals on channels 4-7
// [R21] plate drive and sense per reading
// [R22] coordinate mode runs eight ordered conversions
// [R23] host programs mode, delays, triggers, reads
// [R24] dummy slots read as zero

// ****************************************
// register offsets
// ****************************************
`define OFS_CTRL        8'h00
`define OFS_DELAY       8'h04
`define OFS_STATUS      8'h08
`define OFS_MASK        8'h0c
`define RES_BANK_PRI    3'h1
`define RES_BANK_SEC    3'h2

// ****************************************
// field positions
// ****************************************
`define CTRL_ENABLE     0
`define CTRL_XBLOCK     1
`define CTRL_ONESHOT    2
`define CTRL_IGNORE     3
`define CTRL_START      4
`define CTRL_ROUTE_SEL  5
`define CTRL_PMODE_LSB  6
`define CTRL_C7SEL_LSB  9
`define CTRL_C7HALVE    11
`define CTRL_SECOND     23
`define DLY_BIAS_LSB    0
`define DLY_INTER_LSB   8

// ****************************************
// reset values and timing
// ****************************************
`define MASK_RESET      3'h7
`define DELAY_RESET     16'h0000
`define CLK_MHZ         250
`define PEN_DEB_MS      30
`define PEN_DEB_CYC     (`PEN_DEB_MS * 1000 * `CLK_MHZ)
`endif

// ==== rtl/adc_seq_pkg.sv ====
package adc_seq_pkg;
  // sequencer states, gray in listed order; ST_IDLE to ST_START, ST_CONV to ST_FIN and ST_GAP to ST_START flip two bits
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_BIAS  = 3'h1,
    ST_START = 3'h3,
    ST_CONV  = 3'h2,
    ST_GAP   = 3'h6,
    ST_FIN   = 3'h4
  } seq_state_e;

  // decoded panel mode
  typedef enum logic [1:0] {
    PM_INACTIVE = 2'h0,
    PM_PEN      = 2'h1,
    PM_COORD    = 2'h2,
    PM_RSVD     = 2'h3
  } panel_mode_e;

  // panel switch matrix setting
  typedef enum logic [2:0] {
    SW_GPIO    = 3'h0,
    SW_PEN     = 3'h1,
    SW_XREAD   = 3'h2,
    SW_YREAD   = 3'h3,
    SW_CONTACT = 3'h4,
    SW_OFF     = 3'h5
  } panel_switch_e;
endpackage

// ==== rtl/adc_request_arbiter_touch_seq.sv ====
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "adc_seq_regs.svh"
module adc_request_arbiter_touch_seq import adc_seq_pkg::*; #(
  parameter int DEB_CYC = `PEN_DEB_CYC,
  parameter int DLY_W   = 8
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        hw_trigger_pin_i,
  input  wire logic        pen_contact_i,
  input  wire logic        conv_done_i,
  input  wire logic [9:0]  conv_data_i,
  output logic             conv_start_o,
  output logic      [2:0]  conv_chan_o,
  output logic      [2:0]  panel_switch_o,
  output logic             input_route_select_o,
  output logic      [1:0]  ch_seven_route_o,
  output logic             ch_seven_halve_o,
  output logic             primary_done_irq_o,
  output logic             secondary_done_irq_o,
  output logic             pen_touch_irq_o
);

  // ****************************************
  // declarations
  // ****************************************
  logic             converter_enable_q;
  logic             hw_trigger_ignore_q;
  logic             input_route_select_q;
  logic [2:0]       panel_mode_q;
  logic [1:0]       ch_seven_route_q;
  logic             ch_seven_halve_q;
  logic [1:0]       cross_trigger_block_q;
  logic [1:0]       single_shot_arm_q;
  logic [1:0]       shot_used_q;
  logic [DLY_W-1:0] panel_bias_delay_q;
  logic [DLY_W-1:0] inter_conversion_delay_q;
  logic [2:0]       mask_q;
  logic [1:0]       done_q;
  logic             pen_flag_q;
  logic             pen_state_q;
  logic [31:0]      deb_cnt_q;
  logic [1:0]       pend_q;
  logic             older_q;
  logic             trig_prev_q;
  seq_state_e       state_q;
  logic             act_q;
  logic             coord_q;
  logic [2:0]       slot_q;
  logic [DLY_W-1:0] dly_cnt_q;
  logic [9:0]       res_q [0:15];
  logic [1:0]       irq_q;
  logic             setup_ph;
  logic             wr_en;
  logic             ctrl_wr;
  logic             ctrl_sec;
  logic             stat_wr;
  logic             hw_edge;
  logic             busy;
  logic [1:0]       hw_ok;
  logic [1:0]       sw_ok;
  logic [1:0]       new_req;
  logic [1:0]       grant;
  logic             grant_idx;
  logic             tie_idx;
  logic             is_dummy;
  logic             rd_hit;
  logic [31:0]      rd_mux;
  panel_mode_e      pmode;

  // mode decode: x00 inactive, 001 pen, 01x coordinate, rest reserved
  assign pmode    = (panel_mode_q[1:0] == 2'h0) ? PM_INACTIVE :  // [R18]
                    (panel_mode_q == 3'h1) ? PM_PEN : (panel_mode_q[2:1] == 2'h1) ? PM_COORD : PM_RSVD;
  assign setup_ph = psel_i & penable_i & ~pready_o;
  assign wr_en    = psel_i & penable_i & pready_o & pwrite_i;
  assign ctrl_wr  = wr_en & (paddr_i == `OFS_CTRL);
  assign ctrl_sec = pwdata_i[`CTRL_SECOND];  // [R4]
  assign stat_wr  = wr_en & (paddr_i == `OFS_STATUS);
  assign busy     = (state_q != ST_IDLE);
  assign is_dummy = coord_q & ((slot_q == 3'h2) | (slot_q == 3'h5));

  // ****************************************
  // apb slave
  // ****************************************
  // one wait state: pready rises in the second access cycle
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0;
    end else begin
      pready_o  <= setup_ph;
      pslverr_o <= setup_ph & ~rd_hit;
      if (setup_ph) begin
        prdata_o <= pwrite_i ? 32'h0 : rd_mux;
      end
    end
  end

  // read mux; secondary settings have no read path
  always_comb begin
    rd_mux = 32'h0;
    rd_hit = 1'b1;
    case (paddr_i)
      `OFS_CTRL: begin  // [R5]
        rd_mux[`CTRL_ENABLE]                   = converter_enable_q;
        rd_mux[`CTRL_XBLOCK]                   = cross_trigger_block_q[0];
        rd_mux[`CTRL_ONESHOT]                  = single_shot_arm_q[0];
        rd_mux[`CTRL_IGNORE]                   = hw_trigger_ignore_q;
        rd_mux[`CTRL_ROUTE_SEL]                = input_route_select_q;
        rd_mux[`CTRL_PMODE_LSB+2:`CTRL_PMODE_LSB] = panel_mode_q;
        rd_mux[`CTRL_C7SEL_LSB+1:`CTRL_C7SEL_LSB] = ch_seven_route_q;
        rd_mux[`CTRL_C7HALVE]                  = ch_seven_halve_q;
      end
      `OFS_DELAY: begin
        rd_mux[`DLY_BIAS_LSB+DLY_W-1:`DLY_BIAS_LSB]   = panel_bias_delay_q;
        rd_mux[`DLY_INTER_LSB+DLY_W-1:`DLY_INTER_LSB] = inter_conversion_delay_q;
      end
      `OFS_STATUS: begin
        rd_mux[4:0] = {pen_state_q, busy, pen_flag_q, done_q};
      end
      `OFS_MASK: begin
        rd_mux[2:0] = mask_q;
      end
      default: begin
        // result banks: primary and secondary each eight word slots
        if (paddr_i[1:0] == 2'h0 && (paddr_i[7:5] == `RES_BANK_PRI || paddr_i[7:5] == `RES_BANK_SEC)) begin  // [R3]
          rd_mux[9:0] = res_q[{paddr_i[6], paddr_i[4:2]}];
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  // ****************************************
  // control registers
  // ****************************************
  // shared settings change only on primary-addressed writes
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      converter_enable_q   <= 1'b0;
      hw_trigger_ignore_q  <= 1'b0;
      input_route_select_q <= 1'b0;
      panel_mode_q         <= 3'h0;
      ch_seven_route_q     <= 2'h0;
      ch_seven_halve_q     <= 1'b0;
    end else if (ctrl_wr && !ctrl_sec) begin
      converter_enable_q   <= pwdata_i[`CTRL_ENABLE];
      hw_trigger_ignore_q  <= pwdata_i[`CTRL_IGNORE];
      input_route_select_q <= pwdata_i[`CTRL_ROUTE_SEL];
      panel_mode_q         <= pwdata_i[`CTRL_PMODE_LSB+2:`CTRL_PMODE_LSB];
      ch_seven_route_q     <= pwdata_i[`CTRL_C7SEL_LSB+1:`CTRL_C7SEL_LSB];
      ch_seven_halve_q     <= pwdata_i[`CTRL_C7HALVE];
    end
  end

  // delay settings, counted in clock cycles
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      {inter_conversion_delay_q, panel_bias_delay_q} <= `DELAY_RESET;
      mask_q <= `MASK_RESET;
    end else if (wr_en && paddr_i == `OFS_DELAY) begin
      panel_bias_delay_q       <= pwdata_i[`DLY_BIAS_LSB+DLY_W-1:`DLY_BIAS_LSB];
      inter_conversion_delay_q <= pwdata_i[`DLY_INTER_LSB+DLY_W-1:`DLY_INTER_LSB];
    end else if (wr_en && paddr_i == `OFS_MASK) begin
      mask_q <= pwdata_i[2:0];
    end
  end

  // ****************************************
  // trigger intake and arbitration
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= hw_trigger_pin_i;
    end
  end

  // rising pin edge is the trigger event
  assign hw_edge = hw_trigger_pin_i & ~trig_prev_q & ~hw_trigger_ignore_q & converter_enable_q;  // [R14] [R15]

  // per-request settings, acceptance and queue
  for (genvar i = 0; i < 2; i++) begin : g_req
    assign hw_ok[i] = hw_edge
                    & ~(single_shot_arm_q[i] & shot_used_q[i])          // [R11]
                    & ~(busy & (act_q != i) & cross_trigger_block_q[i]); // [R8] [R9]
    // block bit never looks at software starts; a primary start obeys the enable written with it
    assign sw_ok[i] = ctrl_wr & pwdata_i[`CTRL_START] & (ctrl_sec == i)
                    & (ctrl_sec ? converter_enable_q : pwdata_i[`CTRL_ENABLE]);  // [R10] [R15]
    assign new_req[i] = hw_ok[i] | sw_ok[i];

    always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
        cross_trigger_block_q[i] <= 1'b0;
        single_shot_arm_q[i]     <= 1'b0;
      end else if (ctrl_wr && ctrl_sec == i) begin  // [R4]
        cross_trigger_block_q[i] <= pwdata_i[`CTRL_XBLOCK];
        single_shot_arm_q[i]     <= pwdata_i[`CTRL_ONESHOT];
      end
    end

    // shot stays used until software drops the arm bit
    always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
        shot_used_q[i] <= 1'b0;
      end else if (!single_shot_arm_q[i]) begin  // [R12]
        shot_used_q[i] <= 1'b0;
      end else if (hw_ok[i]) begin  // [R11]
        shot_used_q[i] <= 1'b1;
      end
    end

    // a new event in the grant cycle is kept
    always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
        pend_q[i] <= 1'b0;
      end else begin
        pend_q[i] <= (pend_q[i] & ~grant[i]) | new_req[i];  // [R9] [R13]
      end
    end

    // done flags: set wins over write-one-to-clear
    always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
        done_q[i] <= 1'b0;
        irq_q[i]  <= 1'b0;
      end else begin
        done_q[i] <= (done_q[i] & ~(stat_wr & pwdata_i[i])) | (state_q == ST_FIN && act_q == i);  // [R6]
        irq_q[i]  <= done_q[i] & ~mask_q[i];  // [R6]
      end
    end
  end

  // simultaneous pin events: unblocked one first, else primary
  assign tie_idx   = cross_trigger_block_q[0] & ~cross_trigger_block_q[1];  // [R13]
  assign grant_idx = (pend_q == 2'h3) ? older_q : pend_q[1];  // [R7]
  assign grant[0]  = (state_q == ST_IDLE) & converter_enable_q & pend_q[0] & ~grant_idx;
  assign grant[1]  = (state_q == ST_IDLE) & converter_enable_q & pend_q[1] & grant_idx;

  // remember which queued request came first
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      older_q <= 1'b0;
    end else if (new_req == 2'h3 && pend_q == 2'h0) begin
      older_q <= tie_idx;  // [R13]
    end else if (new_req[0] && !pend_q[1]) begin
      older_q <= 1'b0;  // [R7]
    end else if (new_req[1] && !pend_q[0]) begin
      older_q <= 1'b1;  // [R7]
    end
  end

  // ****************************************
  // conversion sequencer
  // ****************************************
  // eight conversions per request; coordinate mode adds bias and gap delays
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q   <= ST_IDLE;
      act_q     <= 1'b0;
      coord_q   <= 1'b0;
      slot_q    <= 3'h0;
      dly_cnt_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (grant != 2'h0) begin
            act_q     <= grant[1];
            coord_q   <= (pmode == PM_COORD);
            slot_q    <= 3'h0;
            dly_cnt_q <= panel_bias_delay_q;
            state_q   <= (pmode == PM_COORD) ? ST_BIAS : ST_START;  // [R22]
          end
        end
        ST_BIAS, ST_GAP: begin
          if (dly_cnt_q == '0) begin
            state_q <= ST_START;
          end else begin
            dly_cnt_q <= dly_cnt_q - 1'b1;
          end
        end
        ST_START: begin
          state_q <= ST_CONV;
        end
        ST_CONV: begin
          if (conv_done_i) begin
            dly_cnt_q <= inter_conversion_delay_q;
            if (slot_q == 3'h7) begin
              state_q <= ST_FIN;
            end else begin
              slot_q  <= slot_q + 3'h1;  // [R22]
              state_q <= coord_q ? ST_GAP : ST_START;
            end
          end
        end
        ST_FIN: begin
          state_q <= ST_IDLE;  // [R9]
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // result store; dummy slots forced to zero
  always_ff @(posedge clk_sys_i) begin
    if (state_q == ST_CONV && conv_done_i) begin
      res_q[{act_q, slot_q}] <= is_dummy ? 10'h0 : conv_data_i;  // [R3] [R24]
    end
  end

  // ****************************************
  // pen detection
  // ****************************************
  // both edges must hold steady for the whole debounce window
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pen_state_q <= 1'b0;
      deb_cnt_q   <= 32'h0;
      pen_flag_q  <= 1'b0;
      pen_touch_irq_o <= 1'b0;
    end else begin
      pen_touch_irq_o <= pen_flag_q & ~mask_q[2];
      if (pmode != PM_PEN || pen_contact_i == pen_state_q) begin
        deb_cnt_q <= 32'h0;
      end else if (deb_cnt_q == 32'(DEB_CYC - 1)) begin
        deb_cnt_q   <= 32'h0;
        pen_state_q <= pen_contact_i;  // [R19]
      end else begin
        deb_cnt_q <= deb_cnt_q + 32'h1;
      end
      pen_flag_q <= (pen_flag_q & ~(stat_wr & pwdata_i[2]))
                  | (pmode == PM_PEN && pen_contact_i != pen_state_q && deb_cnt_q == 32'(DEB_CYC - 1));  // [R19]
    end
  end

  // ****************************************
  // analog control outputs
  // ****************************************
  // registered so the mux settles with the start pulse
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      conv_start_o     <= 1'b0;
      conv_chan_o      <= 3'h0;
      panel_switch_o   <= SW_GPIO;
      ch_seven_route_o <= 2'h0;
      ch_seven_halve_o <= 1'b0;
    end else begin
      conv_start_o     <= (state_q == ST_START);
      // x read senses y1 (ch6), y read x1 (ch4); dummies already take the next polarity
      conv_chan_o      <= ~coord_q ? slot_q : (slot_q < 3'h2) ? 3'h6 : (slot_q < 3'h5) ? 3'h4 : 3'h7;  // [R20] [R21]
      ch_seven_route_o <= ch_seven_route_q;  // [R1]
      // usb id path always halved, die temperature never
      ch_seven_halve_o <= (ch_seven_route_q == 2'h2)
                        | (ch_seven_halve_q & (ch_seven_route_q[1] == ch_seven_route_q[0]));  // [R2]
      case (pmode)
        PM_INACTIVE: panel_switch_o <= SW_GPIO;  // [R20]
        PM_PEN:      panel_switch_o <= SW_PEN;  // [R19]
        PM_COORD:    panel_switch_o <= ~(busy && coord_q) ? SW_OFF : (slot_q < 3'h2) ? SW_XREAD :
                                       (slot_q < 3'h5) ? SW_YREAD : SW_CONTACT;  // [R21]
        default:     panel_switch_o <= SW_OFF;
      endcase
    end
  end

  assign input_route_select_o = input_route_select_q;
  assign primary_done_irq_o   = irq_q[0];
  assign secondary_done_irq_o = irq_q[1];

endmodule

// ==== dv/adc_core_model.sv ====
`timescale 1ns/1ps
module adc_core_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic [2:0] chan_i,
  input  wire logic [6:0] bank_i,
  output logic            done_o,
  output logic [9:0]      data_o
);
  // ****************************************
  // behavioural converter core
  // ****************************************
  logic       busy_q;
  logic       slow_q;
  logic [3:0] wait_q;
  logic [2:0] chan_q;

  // one conversion at a time; latency alternates short and long
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      busy_q <= 1'b0;
      slow_q <= 1'b0;
      wait_q <= 4'h0;
      chan_q <= 3'h0;
    end else if (start_i) begin
      busy_q <= 1'b1;
      chan_q <= chan_i;
      wait_q <= slow_q ? 4'h6 : 4'h1;
      slow_q <= !slow_q;
    end else if (busy_q) begin
      wait_q <= wait_q - 4'h1;
      if (wait_q == 4'h0) begin
        busy_q <= 1'b0;
        done_o <= 1'b1;
      end
    end
  end

  // result only with done; otherwise toggles so stale data never looks valid
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_o <= 10'h155;
    end else begin
      data_o <= (busy_q && wait_q == 4'h0) ? {bank_i, chan_q} : ~data_o;
    end
  end
endmodule

// ==== dv/adc_seq_checker_sva.sv ====
`timescale 1ns/1ps
module adc_seq_checker_sva import adc_seq_pkg::*; #(
  parameter int DEB_CYC = 20,
  parameter int DLY_W   = 8
) (
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pen_contact_i,
  input wire logic        conv_done_i,
  input wire logic        conv_start_o,
  input wire logic [2:0]  conv_chan_o,
  input wire logic [2:0]  panel_switch_o,
  input wire logic        input_route_select_o,
  input wire logic [1:0]  ch_seven_route_o,
  input wire logic        ch_seven_halve_o,
  input wire logic        pen_touch_irq_o
);
  // ****************************************
  // helper state
  // ****************************************
  logic       acc;
  logic       ctrl_wr;
  logic       sec_wr;
  logic       coord_q;
  logic       fl_q;
  logic       pen_q;
  logic [2:0] idx_q;
  int         same_q;

  function automatic logic [2:0] coord_chan(input logic [2:0] i);
    if (i < 3'h2) return 3'h6;
    if (i < 3'h5) return 3'h4;
    return 3'h7;
  endfunction

  assign acc     = psel_i && penable_i && pready_o;
  assign ctrl_wr = acc && pwrite_i && paddr_i == 8'h00 && !pwdata_i[23];
  assign sec_wr  = acc && pwrite_i && paddr_i == 8'h00 && pwdata_i[23];

  // mode seen at last primary write, slot index, in-flight flag, pen stable count
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      coord_q <= 1'b0;
      fl_q    <= 1'b0;
      idx_q   <= 3'h0;
      pen_q   <= 1'b0;
      same_q  <= 0;
    end else begin
      pen_q  <= pen_contact_i;
      same_q <= (pen_contact_i != pen_q) ? 0 : same_q + 1;
      if (ctrl_wr) coord_q <= pwdata_i[8:7] == 2'b01;
      if (conv_start_o) idx_q <= idx_q + 3'h1;
      if (conv_start_o) fl_q <= 1'b1;
      else if (conv_done_i) fl_q <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_ctrl_wr;
    ctrl_wr;
  endsequence
  sequence s_pen_wr;
    ctrl_wr && pwdata_i[8:6] == 3'b001;
  endsequence

  a_one_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("access not answered after one wait state");
  a_sec_reads_zero: assert property (acc && !pwrite_i && paddr_i == 8'h00 |-> !prdata_o[23])
    else $error("control read shows secondary select set");
  a_route_follow: assert property (s_ctrl_wr |=> ##1 ch_seven_route_o == $past(pwdata_i[10:9], 2))
    else $error("channel seven route not taken from control write");
  a_halve_follow: assert property (s_ctrl_wr |=> ##1 ch_seven_halve_o ==
    ($past(pwdata_i[10:9], 2) == 2'h2 || ($past(pwdata_i[11], 2) && $past(pwdata_i[10:9], 2) != 2'h1)))
    else $error("channel seven halving wrong");
  a_sec_keeps_shared: assert property (sec_wr |=> ##1 $stable(ch_seven_route_o) &&
    $stable(ch_seven_halve_o) && $stable(input_route_select_o))
    else $error("secondary write changed shared settings");
  a_one_in_flight: assert property (conv_start_o |-> !fl_q)
    else $error("conversion started before previous one finished");
  a_chan_order: assert property (conv_start_o |->
    conv_chan_o == (coord_q ? coord_chan(idx_q) : idx_q))
    else $error("conversion channel out of order");
  a_pen_debounce: assert property ($rose(pen_touch_irq_o) |-> same_q >= DEB_CYC - 2)
    else $error("pen interrupt before debounce time");
  a_pen_bias: assert property (s_pen_wr |=> ##2 panel_switch_o == SW_PEN)
    else $error("panel not biased for pen detection");
endmodule

bind adc_request_arbiter_touch_seq adc_seq_checker_sva #(.DEB_CYC(DEB_CYC), .DLY_W(DLY_W)) i_sva (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pen_contact_i(pen_contact_i), .conv_done_i(conv_done_i),
  .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o), .panel_switch_o(panel_switch_o),
  .input_route_select_o(input_route_select_o), .ch_seven_route_o(ch_seven_route_o),
  .ch_seven_halve_o(ch_seven_halve_o), .pen_touch_irq_o(pen_touch_irq_o));

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import adc_seq_pkg::*;
  // ****************************************
  // stimulus and checking
  // ****************************************
  logic        clk_sys, rst, psel, penable, pwrite, trig, pen, cdone, pready, pslverr;
  logic        cstart, rsel, halve, irq_p, irq_s, irq_t, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [9:0]  cdata;
  logic [2:0]  cchan, psw;
  logic [1:0]  route;
  logic [6:0]  bank;
  logic [2:0]  ctab [8] = '{3'h6, 3'h6, 3'h6, 3'h4, 3'h4, 3'h4, 3'h7, 3'h7};
  int          failures = 0;
  int          comparisons = 0;

  adc_request_arbiter_touch_seq #(.DEB_CYC(20)) i_adc_request_arbiter_touch_seq (
    .clk_sys_i(clk_sys), .rst_i(rst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .hw_trigger_pin_i(trig), .pen_contact_i(pen), .conv_done_i(cdone), .conv_data_i(cdata),
    .conv_start_o(cstart), .conv_chan_o(cchan), .panel_switch_o(psw), .input_route_select_o(rsel),
    .ch_seven_route_o(route), .ch_seven_halve_o(halve), .primary_done_irq_o(irq_p),
    .secondary_done_irq_o(irq_s), .pen_touch_irq_o(irq_t));
  adc_core_model i_adc_core_model (.clk_i(clk_sys), .rst_i(rst), .start_i(cstart), .chan_i(cchan),
    .bank_i(bank), .done_o(cdone), .data_o(cdata));

  // clock, 4 ns period
  initial clk_sys = 1'b0;
  always #2 clk_sys = ~clk_sys;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // request held from setup until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    rdata = prdata;
    err   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdata);
  endtask

  // bounded wait for irq w; one edge first so a flag just cleared is not seen stale
  task automatic wait_irq(input int w);
    logic v;
    int   n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
      v = (w == 0) ? irq_p : (w == 1) ? irq_s : irq_t;
    end while (v !== 1'b1 && n < 3000);
    chk("irq", 32'h1, {31'h0, v});
  endtask

  task automatic pulse(input int gap);
    repeat (gap) @(posedge clk_sys);
    trig <= 1'b1;
    @(posedge clk_sys);
    trig <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic tally_and_finish;
    if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog: the whole sequence needs a little over a thousand cycles
  initial begin
    repeat (25000) @(posedge clk_sys);
    failures++;
    tally_and_finish();
  end

  initial begin
    {psel, penable, pwrite, trig, pen, rst} = 6'h1;
    paddr  = 8'h00;
    pwdata = 32'h0;
    bank   = 7'h00;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(8'h0c, 32'h7, "mask reset");
    rd(8'h04, 32'h0, "delay reset");
    rd(8'h10, 32'h0, "unmapped");
    chk("slverr", 32'h1, {31'h0, err});
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, i << 9);
      @(posedge clk_sys);
      chk("route", i[1:0], route);
      chk("halve", i[1:0] == 2'h2 || (i[2] && i[1:0] != 2'h1), halve);
    end
    chk("switch", SW_GPIO, psw);
    wr(8'h00, 32'h0080_0006);
    @(posedge clk_sys);
    chk("route kept", 32'h3, route);
    rd(8'h00, 32'h0000_0e00, "ctrl");
    wr(8'h00, 32'h0080_0000);
    wr(8'h0c, 32'h0);
    bank <= 7'h11;
    wr(8'h00, 32'h11);
    wait_irq(0);
    rd(8'h00, 32'h1, "ctrl start");
    bank <= 7'h12;
    wr(8'h00, 32'h0080_0010);
    wait_irq(1);
    for (int n = 0; n < 8; n++) begin
      rd(8'h20 + 4 * n, {7'h11, n[2:0]}, "pri slot");
      rd(8'h40 + 4 * n, {7'h12, n[2:0]}, "sec slot");
    end
    wr(8'h08, 32'h3);
    @(posedge clk_sys);
    chk("irq clear", 32'h0, {irq_p, irq_s});
    wr(8'h00, 32'h10);
    pulse(2);
    rd(8'h08, 32'h0, "disabled");
    wr(8'h00, 32'h9);
    pulse(2);
    rd(8'h08, 32'h0, "ignored");
    bank <= 7'h22;
    wr(8'h00, 32'h0080_0004);
    wr(8'h00, 32'h5);
    pulse(0);
    wait_irq(0);
    wait_irq(1);
    wr(8'h08, 32'h3);
    pulse(0);
    repeat (40) @(posedge clk_sys);
    rd(8'h08, 32'h0, "single shot");
    wr(8'h00, 32'h1);
    wr(8'h00, 32'h5);
    pulse(0);
    wait_irq(0);
    wr(8'h08, 32'h1);
    wr(8'h00, 32'h0080_0002);
    wr(8'h00, 32'h17);
    pulse(4);
    wait_irq(0);
    wr(8'h08, 32'h1);
    repeat (40) @(posedge clk_sys);
    rd(8'h08, 32'h0, "blocked");
    wr(8'h00, 32'h0080_0000);
    bank <= 7'h33;
    wr(8'h00, 32'h15);
    pulse(4);
    wait_irq(0);
    wait_irq(1);
    rd(8'h40, {7'h33, 3'h0}, "queued");
    wr(8'h08, 32'h3);
    wr(8'h04, 32'h0302);
    bank <= 7'h44;
    wr(8'h00, 32'hb5);
    wait_irq(0);
    wr(8'h00, 32'ha0);
    for (int n = 0; n < 8; n++) begin
      rd(8'h20 + 4 * n, (n == 2 || n == 5) ? 32'h0 : {7'h44, ctab[n]}, "coord");
    end
    wr(8'h08, 32'h1);
    wr(8'h00, 32'h61);
    @(posedge clk_sys);
    chk("switch", SW_PEN, psw);
    pen <= 1'b1;
    repeat (10) @(posedge clk_sys);
    pen <= 1'b0;
    repeat (30) @(posedge clk_sys);
    chk("pen glitch", 32'h0, {31'h0, irq_t});
    pen <= 1'b1;
    wait_irq(2);
    rd(8'h08, 32'h14, "pen status");
    wr(8'h08, 32'h4);
    pen <= 1'b0;
    wait_irq(2);
    tally_and_finish();
  end
endmodule
